// file: rtl/imgr_pkg.sv
// Overview of operation
// (RULE_01) main mask: bits 5,4,3,2,0 mask error2, error1, port, slot, ready; reset 3dh
// (RULE_02) error2 mask bit ignored while the 16-bit host interface is selected
// (RULE_03) error mask one bits 1..0 gate clock failures, reset 3fh; mask two 0ffh
// (RULE_04) read-only port input register mirrors the eight port lines
// (RULE_05) write-only port output register, eight bits, resets to 00h
// (RULE_06) direction bit 0 makes line input, 1 output; all inputs after reset
// (RULE_07) change mask bit 0 enables detection on its line; resets to 0ffh
// (RULE_08) change flag bit reads 1 once a change was seen on that line
// (RULE_09) flag address returns identifier after hardware reset, 00h after software reset
// (RULE_10) slot value command shows the 8-bit slot value in readback
// (RULE_11) pll readback: bits 3..0 source select, bits 6..4 reference frequency code
// (RULE_12) clock output readback returns 00, 01 or 10 for selected clock
// (RULE_13) configuration readbacks echo stored parameter bits at their documented positions
// (RULE_14) aux clock line readback bit 0: 0 clock, 1 frame signal
// (RULE_15) clock-mode aux line: bits 3..1 encode source code 000 to 110
// (RULE_16) frame-mode aux line: bit 1 edge, bits 7..2 low six offset bits
// (RULE_17) line configuration readback bits 1..0 give the line data rate
// (RULE_18) bit shift readback: bit 0 sampling edge, bits 3..1 shift value
// (RULE_19) for input lines bit 4 tells rising or falling frame sync byte
// (RULE_20) software picks the readback view with a 4-bit read-configuration selector
// (RULE_21) main status port-change bit sets on any enabled detected input change
// (RULE_22) interrupt request asserts while any unmasked status indication is set
package imgr_pkg;
  localparam logic [7:0] IMGR_OFF_MAIN_MASK = 8'h12;
  localparam logic [7:0] IMGR_OFF_ERR_MASK1 = 8'h14;
  localparam logic [7:0] IMGR_OFF_ERR_MASK2 = 8'h15;
  localparam logic [7:0] IMGR_OFF_PORT_IN = 8'h16;
  localparam logic [7:0] IMGR_OFF_PORT_OUT = 8'h18;
  localparam logic [7:0] IMGR_OFF_PORT_DIR = 8'h1a;
  localparam logic [7:0] IMGR_OFF_PORT_MASK = 8'h1b;
  localparam logic [7:0] IMGR_OFF_PORT_FLAGS = 8'h1c;
  localparam logic [7:0] IMGR_OFF_READBACK = 8'h1e;
  localparam logic [7:0] IMGR_OFF_STATUS = 8'h0e;
  localparam logic [7:0] IMGR_RST_MAIN_MASK = 8'h3d;
  localparam logic [7:0] IMGR_RST_ERR_MASK1 = 8'h3f;
  localparam logic [7:0] IMGR_RST_ERR_MASK2 = 8'hff;
  localparam logic [7:0] IMGR_RST_PORT_OUT = 8'h00;
  localparam logic [7:0] IMGR_RST_PORT_DIR = 8'h00;
  localparam logic [7:0] IMGR_RST_PORT_MASK = 8'hff;
  localparam logic [7:0] IMGR_RST_ZERO = 8'h00;
  localparam int IMGR_BIT_ERR2 = 5;
  localparam int IMGR_BIT_ERR1 = 4;
  localparam int IMGR_BIT_PORT = 3;
  localparam int IMGR_BIT_SLOT = 2;
  localparam int IMGR_BIT_READY = 0;
  localparam logic [7:0] IMGR_MAIN_MASK_USED = 8'h3d;
  localparam logic [7:0] IMGR_ERR1_MASK_USED = 8'h03;
  // readback views, last command decides
  typedef enum logic [6:0] {
    IMGR_RB_NONE = 7'b000_0001,
    IMGR_RB_SLOT = 7'b000_0010,
    IMGR_RB_CONFIG = 7'b000_0100,
    IMGR_RB_AUXCLK = 7'b000_1000,
    IMGR_RB_LINE = 7'b001_0000,
    IMGR_RB_SHIFT = 7'b010_0000,
    IMGR_RB_HOLD = 7'b100_0000
  } imgr_rb_t;
  localparam logic [3:0] IMGR_SEL_PLL = 4'b0001;
  localparam logic [3:0] IMGR_SEL_CLKOUT = 4'b0101;
  localparam logic [3:0] IMGR_SEL_PHASE = 4'b1001;
  localparam logic [3:0] IMGR_SEL_EXTFREQ = 4'b1010;
  localparam logic [3:0] IMGR_SEL_PARALLEL = 4'b1011;
  localparam logic [3:0] IMGR_SEL_IRQPIN = 4'b1100;
  localparam logic [3:0] IMGR_SEL_STANDBY = 4'b1101;
  localparam logic [3:0] IMGR_SEL_LOOP = 4'b1110;
  localparam logic [3:0] IMGR_SEL_RANGE = 4'b1111;
endpackage

// file: rtl/imgr_top.sv
`timescale 1ns/100ps
module imgr_top import imgr_pkg::*; #(
  // arbitrary neutral identifier value
  parameter logic [7:0] PART_IDENTIFIER = 8'h5a
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // host interface width
  input wire logic host_16bit,
  // status events from the core
  input wire logic ready_ind,
  input wire logic slot_arrived,
  input wire logic error_one_change,
  input wire logic error_two_change,
  input wire logic network_clock_fail_a,
  input wire logic network_clock_fail_b,
  input wire logic [7:0] err2_status,
  // readback command and stored configuration from the core
  input wire logic rb_cmd,
  input wire logic [2:0] rb_kind,
  input wire logic [3:0] rb_select,
  input wire logic [7:0] slot_value,
  input wire logic [3:0] pll_source,
  input wire logic [2:0] pll_freq,
  input wire logic [1:0] clkout_sel,
  input wire logic phase_align,
  input wire logic ext_freq,
  input wire logic parallel_mode,
  input wire logic [2:0] irq_pin_setup,
  input wire logic [1:0] standby_loop_sb,
  input wire logic [1:0] standby_loop_lp,
  input wire logic [3:0] rate_range,
  input wire logic aux_is_frame,
  input wire logic [2:0] aux_clk_src,
  input wire logic aux_frame_edge,
  input wire logic [5:0] aux_offset_low,
  input wire logic [1:0] line_rate,
  input wire logic shift_edge,
  input wire logic [2:0] shift_value,
  input wire logic shift_for_input,
  input wire logic shift_byte_fall,
  // port lines
  input wire logic [7:0] port_line_bits_in,
  output logic [7:0] port_line_bits_out,
  output logic [7:0] port_line_bits_oe,
  // status out
  output logic port_change,
  output logic interrupt_request_pin
);
  logic [7:0] main_mask_reg, err_mask1_reg, err_mask2_reg;
  logic [7:0] port_out_reg, port_dir_reg, port_mask_reg, flags_reg;
  logic [7:0] sync1_reg, sync2_reg, sync3_reg, level_reg;
  logic id_valid_reg;
  logic [7:0] rb_reg, rb_next;
  imgr_rb_t rb_state_reg;
  logic [7:0] rdata_next;
  logic [7:0] change;
  logic [7:0] status_vec;
  logic [7:0] main_eff_mask;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // software-writable masks
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_mask_reg <= IMGR_RST_MAIN_MASK; // RULE_01
      err_mask1_reg <= IMGR_RST_ERR_MASK1; // RULE_03
      err_mask2_reg <= IMGR_RST_ERR_MASK2; // RULE_03
    end else if (soft_rst) begin
      main_mask_reg <= IMGR_RST_MAIN_MASK;
      err_mask1_reg <= IMGR_RST_ERR_MASK1;
      err_mask2_reg <= IMGR_RST_ERR_MASK2;
    end else if (reg_wr) begin
      if (hit(reg_addr, IMGR_OFF_MAIN_MASK))
        main_mask_reg <= reg_wdata & IMGR_MAIN_MASK_USED; // RULE_01
      if (hit(reg_addr, IMGR_OFF_ERR_MASK1))
        err_mask1_reg <= reg_wdata; // RULE_03
      if (hit(reg_addr, IMGR_OFF_ERR_MASK2))
        err_mask2_reg <= reg_wdata; // RULE_03
    end
  end

  // port registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_out_reg <= IMGR_RST_PORT_OUT; // RULE_05
      port_dir_reg <= IMGR_RST_PORT_DIR; // RULE_06
      port_mask_reg <= IMGR_RST_PORT_MASK; // RULE_07
    end else if (soft_rst) begin
      port_out_reg <= IMGR_RST_PORT_OUT;
      port_dir_reg <= IMGR_RST_PORT_DIR;
      port_mask_reg <= IMGR_RST_PORT_MASK;
    end else if (reg_wr) begin
      if (hit(reg_addr, IMGR_OFF_PORT_OUT))
        port_out_reg <= reg_wdata; // RULE_05
      if (hit(reg_addr, IMGR_OFF_PORT_DIR))
        port_dir_reg <= reg_wdata; // RULE_06
      if (hit(reg_addr, IMGR_OFF_PORT_MASK))
        port_mask_reg <= reg_wdata; // RULE_07
    end
  end

  assign port_line_bits_out = port_out_reg;
  assign port_line_bits_oe = port_dir_reg; // RULE_06

  // three-stage synchroniser; change counts when stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= IMGR_RST_ZERO;
      sync2_reg <= IMGR_RST_ZERO;
      sync3_reg <= IMGR_RST_ZERO;
      level_reg <= IMGR_RST_ZERO;
    end else begin
      sync1_reg <= port_line_bits_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 8; i++) begin
        if (sync2_reg[i] == sync3_reg[i])
          level_reg[i] <= sync3_reg[i]; // RULE_04
      end
    end
  end

  // only input lines with detection enabled can flag
  for (genvar g = 0; g < 8; g++) begin : g_det
    assign change[g] = (sync2_reg[g] == sync3_reg[g]) && (sync3_reg[g] != level_reg[g])
                       && !port_mask_reg[g] && !port_dir_reg[g]; // RULE_07
  end

  // flags clear on read; a change in the read cycle wins over the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= IMGR_RST_ZERO;
      id_valid_reg <= 1'b1;
    end else if (soft_rst) begin
      flags_reg <= IMGR_RST_ZERO;
      id_valid_reg <= 1'b0; // RULE_09
    end else begin
      if (reg_rd && hit(reg_addr, IMGR_OFF_PORT_FLAGS)) begin
        flags_reg <= change; // RULE_08
        id_valid_reg <= 1'b0;
      end else begin
        flags_reg <= flags_reg | change; // RULE_08
      end
      if (|change)
        id_valid_reg <= 1'b0;
    end
  end

  assign port_change = |flags_reg; // RULE_21

  // readback view, selected by last read command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rb_state_reg <= IMGR_RB_NONE;
      rb_reg <= IMGR_RST_ZERO;
    end else begin
      if (rb_cmd) begin
        case (rb_kind)
          3'd1: rb_state_reg <= IMGR_RB_SLOT;
          3'd2: rb_state_reg <= IMGR_RB_CONFIG; // RULE_20
          3'd3: rb_state_reg <= IMGR_RB_AUXCLK;
          3'd4: rb_state_reg <= IMGR_RB_LINE;
          3'd5: rb_state_reg <= IMGR_RB_SHIFT;
          default: rb_state_reg <= IMGR_RB_HOLD;
        endcase
      end
      rb_reg <= rb_next;
    end
  end

  always_comb begin
    rb_next = IMGR_RST_ZERO;
    case (rb_state_reg)
      IMGR_RB_SLOT: rb_next = slot_value; // RULE_10
      IMGR_RB_CONFIG: begin
        case (rb_select)
          IMGR_SEL_PLL: rb_next = {1'b0, pll_freq, pll_source}; // RULE_11
          IMGR_SEL_CLKOUT: rb_next = {6'd0, clkout_sel}; // RULE_12
          IMGR_SEL_PHASE: rb_next = {4'd0, phase_align, 3'd0}; // RULE_13
          IMGR_SEL_EXTFREQ: rb_next = {7'd0, ext_freq}; // RULE_13
          IMGR_SEL_PARALLEL: rb_next = {7'd0, parallel_mode}; // RULE_13
          IMGR_SEL_IRQPIN: rb_next = {5'd0, irq_pin_setup}; // RULE_13
          IMGR_SEL_STANDBY: rb_next = {6'd0, standby_loop_sb}; // RULE_13
          IMGR_SEL_LOOP: rb_next = {6'd0, standby_loop_lp}; // RULE_13
          IMGR_SEL_RANGE: rb_next = {4'd0, rate_range}; // RULE_13
          default: rb_next = IMGR_RST_ZERO;
        endcase
      end
      IMGR_RB_AUXCLK: begin
        if (aux_is_frame)
          rb_next = {aux_offset_low, aux_frame_edge, 1'b1}; // RULE_14 RULE_16
        else
          rb_next = {4'd0, aux_clk_src, 1'b0}; // RULE_14 RULE_15
      end
      IMGR_RB_LINE: rb_next = {6'd0, line_rate}; // RULE_17
      IMGR_RB_SHIFT: begin
        rb_next = {4'd0, shift_value, shift_edge}; // RULE_18
        if (shift_for_input)
          rb_next[4] = shift_byte_fall; // RULE_19
      end
      IMGR_RB_HOLD: rb_next = rb_reg;
      default: rb_next = IMGR_RST_ZERO;
    endcase
  end

  // interrupt request from unmasked indications
  always_comb begin
    main_eff_mask = main_mask_reg;
    if (host_16bit)
      main_eff_mask[IMGR_BIT_ERR2] = 1'b1; // RULE_02
    status_vec = IMGR_RST_ZERO;
    status_vec[IMGR_BIT_READY] = ready_ind;
    status_vec[IMGR_BIT_SLOT] = slot_arrived;
    status_vec[IMGR_BIT_PORT] = port_change; // RULE_21
    status_vec[IMGR_BIT_ERR1] = error_one_change;
    status_vec[IMGR_BIT_ERR2] = error_two_change;
  end

  assign interrupt_request_pin = |(status_vec & ~main_eff_mask & IMGR_MAIN_MASK_USED)
    | |({network_clock_fail_b, network_clock_fail_a} & ~err_mask1_reg[1:0]) // RULE_03
    | |(err2_status & ~err_mask2_reg); // RULE_22

  // read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_next = IMGR_RST_ZERO;
    case (reg_addr)
      IMGR_OFF_MAIN_MASK: rdata_next = main_mask_reg;
      IMGR_OFF_ERR_MASK1: rdata_next = err_mask1_reg;
      IMGR_OFF_ERR_MASK2: rdata_next = err_mask2_reg;
      IMGR_OFF_PORT_IN: rdata_next = level_reg; // RULE_04
      IMGR_OFF_PORT_DIR: rdata_next = port_dir_reg;
      IMGR_OFF_PORT_MASK: rdata_next = port_mask_reg;
      IMGR_OFF_PORT_FLAGS: rdata_next = id_valid_reg ? PART_IDENTIFIER : flags_reg; // RULE_09
      IMGR_OFF_READBACK: rdata_next = rb_reg;
      IMGR_OFF_STATUS: rdata_next = status_vec;
      default: rdata_next = IMGR_RST_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      reg_rdata <= IMGR_RST_ZERO;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= IMGR_RST_ZERO;
  end

  chk_main_mask_reset: assert property (@(posedge core_clk) // RULE_01
    $fell(rst) |-> main_mask_reg == IMGR_RST_MAIN_MASK)
    else $error("main mask reset value wrong");
  chk_err_mask_reset: assert property (@(posedge core_clk) // RULE_03
    $fell(rst) |-> err_mask1_reg == IMGR_RST_ERR_MASK1 && err_mask2_reg == IMGR_RST_ERR_MASK2)
    else $error("error mask reset value wrong");
  chk_port_reset: assert property (@(posedge core_clk) // RULE_05 RULE_06 RULE_07
    $fell(rst) |-> port_out_reg == IMGR_RST_PORT_OUT && port_dir_reg == IMGR_RST_PORT_DIR
    && port_mask_reg == IMGR_RST_PORT_MASK)
    else $error("port reset value wrong");
  chk_err2_ignored: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
    host_16bit && error_two_change && !slot_arrived && !ready_ind && !error_one_change
    && !port_change && !network_clock_fail_a && !network_clock_fail_b && err2_status == 0
    |-> !interrupt_request_pin)
    else $error("error2 indication leaks in 16-bit mode");
  chk_err_mask_gate: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    network_clock_fail_a && !err_mask1_reg[0] |-> interrupt_request_pin)
    else $error("unmasked clock failure gives no request");
  chk_err2_gate: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    |(err2_status & ~err_mask2_reg) |-> interrupt_request_pin)
    else $error("unmasked error status gives no request");
  chk_irq_unmasked: assert property (@(posedge core_clk) disable iff (rst) // RULE_22
    (ready_ind && !main_mask_reg[IMGR_BIT_READY])
    || (slot_arrived && !main_mask_reg[IMGR_BIT_SLOT])
    || (error_one_change && !main_mask_reg[IMGR_BIT_ERR1]) |-> interrupt_request_pin)
    else $error("unmasked indication gives no request");
  chk_port_out_write: assert property (@(posedge core_clk) // RULE_05
    disable iff (rst || soft_rst)
    reg_wr && reg_addr == IMGR_OFF_PORT_OUT |=> port_line_bits_out == $past(reg_wdata))
    else $error("port output write lost");
  chk_dir_oe: assert property (@(posedge core_clk) disable iff (rst) // RULE_06
    port_line_bits_oe == port_dir_reg)
    else $error("direction not applied");
  chk_masked_line: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
    port_mask_reg[0] |=> !(flags_reg[0] && !$past(flags_reg[0])))
    else $error("masked line raised a flag");
  chk_flag_sticky: assert property (@(posedge core_clk) // RULE_08
    disable iff (rst || soft_rst) flags_reg[0] && !reg_rd |=> flags_reg[0])
    else $error("change flag dropped without read");
  chk_soft_id: assert property (@(posedge core_clk) disable iff (rst) // RULE_09
    soft_rst |=> !id_valid_reg ##0 flags_reg == 8'h00)
    else $error("software reset did not clear flags");
  chk_id_after_reset: assert property (@(posedge core_clk) // RULE_09
    $fell(rst) |-> id_valid_reg && flags_reg == 8'h00)
    else $error("identifier not shown after reset");
  chk_read_latency: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  chk_flag_set: assert property (@(posedge core_clk) // RULE_08
    disable iff (rst || soft_rst) |change |=> (flags_reg & $past(change)) == $past(change))
    else $error("detected change not flagged");
  chk_port_change_set: assert property (@(posedge core_clk) // RULE_21
    disable iff (rst || soft_rst) |change |=> port_change)
    else $error("port change bit not set");
  chk_port_in_read: assert property (@(posedge core_clk) disable iff (rst) // RULE_04
    reg_rd && reg_addr == IMGR_OFF_PORT_IN |=> reg_rdata == $past(level_reg))
    else $error("port input read wrong");
  chk_slot_view: assert property (@(posedge core_clk) disable iff (rst) // RULE_10
    rb_state_reg == IMGR_RB_SLOT |=> rb_reg == $past(slot_value))
    else $error("slot readback wrong");
  chk_pll_view: assert property (@(posedge core_clk) disable iff (rst) // RULE_11
    rb_state_reg == IMGR_RB_CONFIG && rb_select == IMGR_SEL_PLL
    |=> rb_reg == {1'b0, $past(pll_freq), $past(pll_source)})
    else $error("pll readback wrong");
  chk_clkout_view: assert property (@(posedge core_clk) disable iff (rst) // RULE_12
    rb_state_reg == IMGR_RB_CONFIG && rb_select == IMGR_SEL_CLKOUT
    |=> rb_reg == {6'h00, $past(clkout_sel)})
    else $error("clock output readback wrong");
  chk_aux_clock_view: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    rb_state_reg == IMGR_RB_AUXCLK && !aux_is_frame
    |=> rb_reg == {4'h0, $past(aux_clk_src), 1'b0})
    else $error("aux clock readback wrong");
  chk_aux_frame_view: assert property (@(posedge core_clk) disable iff (rst) // RULE_16
    rb_state_reg == IMGR_RB_AUXCLK && aux_is_frame
    |=> rb_reg == {$past(aux_offset_low), $past(aux_frame_edge), 1'b1})
    else $error("aux frame readback wrong");
  chk_line_view: assert property (@(posedge core_clk) disable iff (rst) // RULE_17
    rb_state_reg == IMGR_RB_LINE |=> rb_reg == {6'h00, $past(line_rate)})
    else $error("line rate readback wrong");
  chk_shift_view: assert property (@(posedge core_clk) disable iff (rst) // RULE_18
    rb_state_reg == IMGR_RB_SHIFT |=> rb_reg[3:0] == {$past(shift_value), $past(shift_edge)})
    else $error("bit shift readback wrong");
  chk_shift_byte: assert property (@(posedge core_clk) disable iff (rst) // RULE_19
    rb_state_reg == IMGR_RB_SHIFT && shift_for_input |=> rb_reg[4] == $past(shift_byte_fall))
    else $error("byte shift readback wrong");
  cov_port_flag: cover property (@(posedge core_clk) disable iff (rst) $rose(port_change));
  cov_irq: cover property (@(posedge core_clk) disable iff (rst) $rose(interrupt_request_pin));
  cov_id_read: cover property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == IMGR_OFF_PORT_FLAGS && id_valid_reg);
  cov_hold_view: cover property (@(posedge core_clk) disable iff (rst) rb_state_reg == IMGR_RB_HOLD);
  cov_soft_reset: cover property (@(posedge core_clk) $fell(soft_rst));
endmodule

// file: testbench/imgr_tb.sv
`timescale 1ns/100ps
module tb import imgr_pkg::*;;
  logic core_clk = 0, rst = 1, soft_rst = 0, reg_wr = 0, reg_rd = 0, host_16bit = 0, rb_cmd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, err2_status = 0, slot_value = 0, pin_ext = 0;
  logic [3:0] ev = 0, pll_source = 0, rb_select = 0, rate_range = 0;
  logic [2:0] rb_kind = 0, pll_freq = 0, irq_pin_setup = 0, aux_clk_src = 0, shift_value = 0;
  logic [1:0] clkout_sel = 0, standby_loop_sb = 0, standby_loop_lp = 0, line_rate = 0;
  logic [5:0] aux_offset_low = 0;
  logic fail_a = 0, fail_b = 0, phase_align = 0, ext_freq = 0, parallel_mode = 0, aux_is_frame = 0;
  logic aux_frame_edge = 0, shift_edge = 0, shift_for_input = 0, shift_byte_fall = 0, rd_q = 0;
  logic [7:0] pins_in, pins_out, pins_oe, m8;
  logic port_change, irq;
  logic [15:0] notes [$];
  logic [15:0] n;
  logic [31:0] r1, r2;
  integer seed = 32'h394c8c80;
  int num_errors = 0, comparisons = 0, cycles = 0;
  logic [3:0] sels [9] = '{IMGR_SEL_PLL, IMGR_SEL_CLKOUT, IMGR_SEL_PHASE, IMGR_SEL_EXTFREQ,
    IMGR_SEL_PARALLEL, IMGR_SEL_IRQPIN, IMGR_SEL_STANDBY, IMGR_SEL_LOOP, IMGR_SEL_RANGE};
  int ibit [4] = '{0, 2, 4, 5};
  // the wire level: driven lines follow the design, the rest follow the outside world
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & pin_ext);
  imgr_top dut (.core_clk(core_clk), .rst(rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_16bit(host_16bit), .ready_ind(ev[0]), .slot_arrived(ev[1]), .error_one_change(ev[2]),
    .error_two_change(ev[3]), .network_clock_fail_a(fail_a), .network_clock_fail_b(fail_b),
    .err2_status(err2_status), .rb_cmd(rb_cmd), .rb_kind(rb_kind), .rb_select(rb_select),
    .slot_value(slot_value), .pll_source(pll_source), .pll_freq(pll_freq),
    .clkout_sel(clkout_sel), .phase_align(phase_align), .ext_freq(ext_freq),
    .parallel_mode(parallel_mode), .irq_pin_setup(irq_pin_setup),
    .standby_loop_sb(standby_loop_sb), .standby_loop_lp(standby_loop_lp),
    .rate_range(rate_range), .aux_is_frame(aux_is_frame), .aux_clk_src(aux_clk_src),
    .aux_frame_edge(aux_frame_edge), .aux_offset_low(aux_offset_low), .line_rate(line_rate),
    .shift_edge(shift_edge), .shift_value(shift_value), .shift_for_input(shift_for_input),
    .shift_byte_fall(shift_byte_fall), .port_line_bits_in(pins_in),
    .port_line_bits_out(pins_out), .port_line_bits_oe(pins_oe), .port_change(port_change),
    .interrupt_request_pin(irq));
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      close_out();
    end
  end
  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_q) begin
      n = notes.pop_front();
      chk(reg_rdata & n[15:8], n[7:0], "register read");
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    notes.push_back({m, e & m});
    @(posedge core_clk);
    reg_rd <= 0;
  endtask
  task automatic rb_case(input logic [2:0] k, input logic [3:0] s);
    logic [7:0] e, m;
    r1 = $random(seed);
    r2 = $random(seed);
    @(posedge core_clk);
    {rate_range, standby_loop_lp, standby_loop_sb, irq_pin_setup} <= r1[30:20];
    {parallel_mode, ext_freq, phase_align, pll_freq, pll_source} <= r1[17:8];
    slot_value <= r1[7:0];
    clkout_sel <= r1[31] ? 2'b10 : {1'b0, r2[31]};
    {aux_offset_low, aux_frame_edge, aux_is_frame} <= r2[7:0];
    aux_clk_src <= (r2[10:8] == 3'd7) ? 3'd6 : r2[10:8];
    {shift_byte_fall, shift_for_input, shift_value, shift_edge, line_rate} <= r2[18:11];
    rb_cmd <= 1;
    rb_kind <= k;
    rb_select <= s;
    @(posedge core_clk);
    rb_cmd <= 0;
    repeat (2) @(posedge core_clk);
    m = 8'h0f;
    e = {4'h0, rate_range};
    case (k)
      3'd1: {m, e} = {8'hff, slot_value};
      3'd3: {m, e} = aux_is_frame ? {8'hff, aux_offset_low, aux_frame_edge, 1'b1}
                                  : {8'h0f, 4'h0, aux_clk_src, 1'b0};
      3'd4: {m, e} = {8'h03, 6'h00, line_rate};
      3'd5: {m, e} = {8'h1f, 3'h0, shift_for_input & shift_byte_fall, shift_value,
                      shift_edge};
      default: begin
        if (s == IMGR_SEL_PLL) {m, e} = {8'h7f, 1'b0, pll_freq, pll_source};
        if (s == IMGR_SEL_CLKOUT) {m, e} = {8'h03, 6'h00, clkout_sel};
        if (s == IMGR_SEL_PHASE) {m, e} = {8'h08, 4'h0, phase_align, 3'h0};
        if (s == IMGR_SEL_EXTFREQ) {m, e} = {8'h01, 7'h00, ext_freq};
        if (s == IMGR_SEL_PARALLEL) {m, e} = {8'h01, 7'h00, parallel_mode};
        if (s == IMGR_SEL_IRQPIN) {m, e} = {8'h07, 5'h00, irq_pin_setup};
        if (s == IMGR_SEL_STANDBY) {m, e} = {8'h03, 6'h00, standby_loop_sb};
        if (s == IMGR_SEL_LOOP) {m, e} = {8'h03, 6'h00, standby_loop_lp};
      end
    endcase
    rd(IMGR_OFF_READBACK, e, m);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 0;
    rd(IMGR_OFF_MAIN_MASK, 8'h3d, 8'hff);
    rd(IMGR_OFF_ERR_MASK1, 8'h3f, 8'hff);
    rd(IMGR_OFF_ERR_MASK2, 8'hff, 8'hff);
    rd(IMGR_OFF_PORT_DIR, 8'h00, 8'hff);
    rd(IMGR_OFF_PORT_MASK, 8'hff, 8'hff);
    rd(IMGR_OFF_PORT_FLAGS, 8'h5a, 8'hff);
    rd(IMGR_OFF_PORT_FLAGS, 8'h00, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    rd(IMGR_OFF_READBACK, 8'h00, 8'hff);
    chk(pins_out, 8'h00, "port output reset");
    // line 0 drives high, line 3 enabled input, line 6 masked input
    wr(IMGR_OFF_PORT_OUT, 8'h01);
    wr(IMGR_OFF_PORT_DIR, 8'h01);
    wr(IMGR_OFF_PORT_MASK, 8'hf6);
    pin_ext <= 8'h48;
    repeat (8) @(posedge core_clk);
    chk({7'h0, port_change}, 8'h01, "port change level");
    rd(IMGR_OFF_STATUS, 8'h08, 8'hff);
    rd(IMGR_OFF_PORT_FLAGS, 8'h08, 8'hff);
    rd(IMGR_OFF_PORT_FLAGS, 8'h00, 8'hff);
    rd(IMGR_OFF_PORT_IN, 8'h49, 8'hff);
    repeat (3) @(negedge core_clk);
    chk({7'h0, port_change}, 8'h00, "port change cleared");
    for (int i = 0; i < 3; i++) begin
      r1 = $random(seed);
      wr(IMGR_OFF_PORT_OUT, r1[7:0]);
      wr(IMGR_OFF_PORT_DIR, r1[15:8]);
      @(negedge core_clk);
      chk(pins_out, r1[7:0], "port output");
      chk(pins_oe, r1[15:8], "port direction");
      rd(IMGR_OFF_PORT_OUT, 8'h00, 8'hff);
      wr(IMGR_OFF_MAIN_MASK, r1[23:16]);
      rd(IMGR_OFF_MAIN_MASK, r1[23:16] & 8'h3d, 8'hff);
      wr(IMGR_OFF_ERR_MASK1, r1[31:24]);
      rd(IMGR_OFF_ERR_MASK1, r1[31:24], 8'h03);
      wr(IMGR_OFF_ERR_MASK2, r1[15:8]);
      rd(IMGR_OFF_ERR_MASK2, r1[15:8], 8'hff);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      ev <= 4'(1 << i);
      wr(IMGR_OFF_MAIN_MASK, 8'h3d);
      @(negedge core_clk);
      chk({7'h0, irq}, 8'h00, "masked indication");
      wr(IMGR_OFF_MAIN_MASK, 8'h3d & ~(8'h01 << ibit[i]));
      @(negedge core_clk);
      chk({7'h0, irq}, 8'h01, "unmasked indication");
    end
    @(posedge core_clk);
    host_16bit <= 1;
    @(negedge core_clk);
    chk({7'h0, irq}, 8'h00, "error two in wide host mode");
    // drive both failure lines masked and unmasked, all four mask settings used
    for (int i = 0; i < 8; i++) begin
      r1 = $random(seed);
      r2 = r1[8] ? 32'hff : {24'h0, r1[23:16]};
      m8 = {6'h3f, i[2], i[2] ^ i[0]};
      wr(IMGR_OFF_ERR_MASK1, m8);
      wr(IMGR_OFF_ERR_MASK2, r2[7:0]);
      {fail_b, fail_a} <= 2'(i);
      err2_status <= r1[7:0];
      r2[15:8] = {7'h0, |(2'(i) & ~m8[1:0]) | |(r1[7:0] & ~r2[7:0])};
      @(negedge core_clk);
      chk({7'h0, irq}, r2[15:8], "error masks");
    end
    for (int i = 0; i < 2; i++) begin
      rb_case(3'd1, 4'h0);
      foreach (sels[j]) rb_case(3'd2, sels[j]);
      repeat (3) rb_case(3'd3, 4'h0);
      rb_case(3'd4, 4'h0);
      repeat (3) rb_case(3'd5, 4'h0);
    end
    // an unknown command must freeze the last view
    rb_case(3'd1, 4'h0);
    @(posedge core_clk);
    rb_cmd <= 1;
    rb_kind <= 3'd7;
    @(posedge core_clk);
    rb_cmd <= 0;
    slot_value <= ~slot_value;
    repeat (2) @(posedge core_clk);
    rd(IMGR_OFF_READBACK, ~slot_value, 8'hff);
    @(posedge core_clk);
    soft_rst <= 1;
    @(posedge core_clk);
    soft_rst <= 0;
    rd(IMGR_OFF_MAIN_MASK, 8'h3d, 8'hff);
    rd(IMGR_OFF_ERR_MASK2, 8'hff, 8'hff);
    rd(IMGR_OFF_PORT_MASK, 8'hff, 8'hff);
    rd(IMGR_OFF_PORT_FLAGS, 8'h00, 8'hff);
    @(negedge core_clk);
    chk(pins_oe, 8'h00, "direction after soft reset");
    chk(pins_out, 8'h00, "output after soft reset");
    repeat (3) @(posedge core_clk);
    chk(8'(notes.size()), 8'h00, "reads left unanswered");
    close_out();
  end
endmodule
